// >>> icta_core.sv
// Instruction cycle sequencer with accumulator, carry and zero state.
`timescale 1ns/1ps
module icta_core
  import icta_pkg::*;
(
  // Clock and reset
  input  wire logic                      clock,
  input  wire logic                      resetn,
  // Instruction presented for each instruction cycle
  input  wire icta_pkg::icta_op_t        instr_op,
  input  wire logic [icta_pkg::DATA_W-1:0] instr_imm,
  input  wire logic                      instr_dest_pcl,
  input  wire logic                      skip_cond,
  input  wire logic [icta_pkg::DATA_W-1:0] reg_rdata,
  // Register write port
  output logic                           reg_we,
  output logic [icta_pkg::DATA_W-1:0]    reg_wdata,
  output logic                           pcl_we,
  // Cycle and flow status
  output logic                           cycle_strobe,
  output logic                           instr_take,
  output logic                           flush_cycle,
  // Core state
  output logic [icta_pkg::DATA_W-1:0]    acc,
  output logic                           carry,
  output logic                           zero
);
  import icta_pkg::*;

  icta_phase_t phase;
  icta_phase_t next_phase;
  logic        flush;
  logic        next_flush;

  icta_alu_if alu_bus ();

  icta_alu u_alu (
    .bus (alu_bus.alu)
  );

  assign alu_bus.op       = instr_op;
  assign alu_bus.acc      = acc;
  assign alu_bus.reg_in   = reg_rdata;
  assign alu_bus.imm      = instr_imm;
  assign alu_bus.carry_in = carry;

  // Gray-coded phase counter; the last phase closes an instruction cycle.
  always_comb begin
    unique case (phase)
      ICTA_PH0: next_phase = ICTA_PH1;
      ICTA_PH1: next_phase = ICTA_PH2;
      ICTA_PH2: next_phase = ICTA_PH3;
      ICTA_PH3: next_phase = ICTA_PH0;
    endcase
  end

  wire last_phase = (phase == ICTA_PH3);
  wire execute    = last_phase && !flush;

  // Flow changes cost one extra cycle in which the prefetch is dropped.
  wire is_flow    = instr_op inside {ICTA_JUMP, ICTA_CALL, ICTA_SUB_RET,
                                     ICTA_INT_RET};
  wire is_table   = (instr_op == ICTA_TABLE_RD);
  wire pcl_write  = instr_dest_pcl && alu_bus.to_reg;
  wire skip_taken = (instr_op == ICTA_SKIP) && skip_cond;
  wire two_cycle  = is_flow || is_table || pcl_write || skip_taken;

  assign next_flush = last_phase ? (execute && two_cycle) : flush;

  wire acc_we   = execute && alu_bus.to_acc;
  wire r_we     = execute && alu_bus.to_reg;
  wire c_we     = execute && alu_bus.carry_we;
  wire z_we     = execute && alu_bus.zero_we;

  always_ff @(posedge clock) begin
    if (!resetn) begin
      phase <= ICTA_PH0;
      flush <= 1'b0;
    end else begin
      phase <= next_phase;
      flush <= next_flush;
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      acc   <= ACC_RESET;
      carry <= CARRY_RESET;
      zero  <= ZERO_RESET;
    end else begin
      if (acc_we) begin
        acc <= alu_bus.result;
      end
      if (c_we) begin
        carry <= alu_bus.carry_out;
      end
      if (z_we) begin
        zero <= alu_bus.zero_out;
      end
    end
  end

  // Write port and status are registered so every output is a flop.
  always_ff @(posedge clock) begin
    if (!resetn) begin
      reg_we       <= 1'b0;
      reg_wdata    <= 8'h00;
      pcl_we       <= 1'b0;
      cycle_strobe <= 1'b0;
      instr_take   <= 1'b0;
      flush_cycle  <= 1'b0;
    end else begin
      reg_we       <= r_we && !instr_dest_pcl;
      reg_wdata    <= alu_bus.result;
      pcl_we       <= r_we && instr_dest_pcl;
      cycle_strobe <= last_phase;
      instr_take   <= execute;
      flush_cycle  <= last_phase && flush;
    end
  end

  AST_CYCLE_FOUR: assert property (@(posedge clock) disable iff (!resetn)
    cycle_strobe |=> !cycle_strobe [*3] ##1 cycle_strobe)
    else $error("Instruction cycle is not four clocks.");

  AST_FLOW_EXTRA: assert property (@(posedge clock) disable iff (!resetn)
    (execute && is_flow) |-> ##5 flush_cycle)
    else $error("Flow instruction took no extra cycle.");

  AST_TABLE_EXTRA: assert property (@(posedge clock) disable iff (!resetn)
    (execute && is_table) |-> ##4 flush ##1 flush_cycle)
    else $error("Table read took no second cycle.");

  AST_PCL_EXTRA: assert property (@(posedge clock) disable iff (!resetn)
    (execute && pcl_write) |=> pcl_we ##4 flush_cycle)
    else $error("Program counter write took no extra cycle.");

  AST_SKIP_TIME: assert property (@(posedge clock) disable iff (!resetn)
    (execute && instr_op == ICTA_SKIP) |=>
      ##4 (flush_cycle == $past(skip_cond, 5)))
    else $error("Skip timing wrong.");

  AST_ONE_CYCLE: assert property (@(posedge clock) disable iff (!resetn)
    (execute && !two_cycle) |=> ##4 (instr_take && !flush_cycle))
    else $error("Ordinary instruction stretched.");

  AST_NO_UPDATE: assert property (@(posedge clock) disable iff (!resetn)
    flush_cycle |-> $stable(acc) && $stable(carry) && !reg_we)
    else $error("State changed in discarded cycle.");

  AST_ADD_CARRY: assert property (@(posedge clock) disable iff (!resetn)
    (execute && instr_op == ICTA_ADD) |=>
      carry == (({1'b0, $past(acc)} + {1'b0, $past(reg_rdata)}) > 9'd255))
    else $error("Add carry wrong.");

  AST_ZERO_LOGIC: assert property (@(posedge clock) disable iff (!resetn)
    (execute && alu_bus.zero_we) |=> zero == (acc == 8'h00))
    else $error("Zero flag wrong after logic operation.");

  AST_INC_ACC: assert property (@(posedge clock) disable iff (!resetn)
    (execute && instr_op == ICTA_INC_A) |=> acc == $past(acc) + 8'h01)
    else $error("Accumulator increment wrong.");

  AST_RLC: assert property (@(posedge clock) disable iff (!resetn)
    (execute && instr_op == ICTA_RLC) |=>
      acc == {$past(acc[6:0]), $past(carry)} && carry == $past(acc[7]))
    else $error("Rotate left through carry wrong.");

  AST_MOVE_TO_REG: assert property (@(posedge clock) disable iff (!resetn)
    (execute && instr_op == ICTA_MOVE_A_TO_R && !instr_dest_pcl) |=>
      reg_we && reg_wdata == $past(acc) && $stable(acc))
    else $error("Move to register wrong.");

endmodule : icta_core

// >>> icta_pkg.sv
// Package of constants and types for the instruction cycle timing block.
package icta_pkg;

  localparam int unsigned PHASES_PER_CYCLE = 4;
  localparam int unsigned DATA_W           = 8;
  localparam int unsigned OP_W             = 5;

  typedef enum logic [1:0] {
    ICTA_PH0 = 2'b00,
    ICTA_PH1 = 2'b01,
    ICTA_PH2 = 2'b11,
    ICTA_PH3 = 2'b10
  } icta_phase_t;

  typedef enum logic [OP_W-1:0] {
    ICTA_NOP         = 5'h00,
    ICTA_MOVE_R_TO_A = 5'h01,
    ICTA_MOVE_A_TO_R = 5'h02,
    ICTA_MOVE_K_TO_A = 5'h03,
    ICTA_ADD         = 5'h04,
    ICTA_SUB         = 5'h05,
    ICTA_INC_R       = 5'h06,
    ICTA_INC_A       = 5'h07,
    ICTA_DEC_R       = 5'h08,
    ICTA_DEC_A       = 5'h09,
    ICTA_AND         = 5'h0A,
    ICTA_OR          = 5'h0B,
    ICTA_XOR         = 5'h0C,
    ICTA_CPL         = 5'h0D,
    ICTA_RR          = 5'h0E,
    ICTA_RL          = 5'h0F,
    ICTA_RRC         = 5'h10,
    ICTA_RLC         = 5'h11,
    ICTA_JUMP        = 5'h12,
    ICTA_CALL        = 5'h13,
    ICTA_SUB_RET     = 5'h14,
    ICTA_INT_RET     = 5'h15,
    ICTA_TABLE_RD    = 5'h16,
    ICTA_SKIP        = 5'h17
  } icta_op_t;

  localparam logic [DATA_W-1:0] ACC_RESET = 8'h00;
  localparam logic              CARRY_RESET = 1'b0;
  localparam logic              ZERO_RESET  = 1'b0;

endpackage : icta_pkg

// >>> icta_alu_if.sv
// Interface carrying operands and results between the core and its ALU.
`timescale 1ns/1ps
interface icta_alu_if;
  import icta_pkg::*;
  icta_op_t          op;
  logic [DATA_W-1:0] acc;
  logic [DATA_W-1:0] reg_in;
  logic [DATA_W-1:0] imm;
  logic              carry_in;
  logic [DATA_W-1:0] result;
  logic              carry_out;
  logic              carry_we;
  logic              zero_out;
  logic              zero_we;
  logic              to_acc;
  logic              to_reg;
  modport core (output op, acc, reg_in, imm, carry_in,
                input result, carry_out, carry_we, zero_out, zero_we,
                to_acc, to_reg);
  modport alu  (input op, acc, reg_in, imm, carry_in,
                output result, carry_out, carry_we, zero_out, zero_we,
                to_acc, to_reg);
endinterface : icta_alu_if

// >>> icta_alu.sv
// Combinational data path: moves, arithmetic, logic and rotates.
`timescale 1ns/1ps
module icta_alu (
  // Operands and results
  icta_alu_if.alu bus
);
  import icta_pkg::*;

  wire [DATA_W:0]   add_sum  = {1'b0, bus.acc} + {1'b0, bus.reg_in};
  wire [DATA_W:0]   sub_dif  = {1'b0, bus.acc} - {1'b0, bus.reg_in};
  wire [DATA_W-1:0] inc_val  = bus.reg_in + 8'h01;
  wire [DATA_W-1:0] dec_val  = bus.reg_in - 8'h01;
  wire [DATA_W-1:0] increment_to_acc_val = bus.acc + 8'h01;
  wire [DATA_W-1:0] decrement_to_acc_val = bus.acc - 8'h01;
  wire [DATA_W-1:0] rr_val   = {bus.acc[0], bus.acc[DATA_W-1:1]};
  wire [DATA_W-1:0] rl_val   = {bus.acc[DATA_W-2:0], bus.acc[DATA_W-1]};
  wire [DATA_W-1:0] rrc_val  = {bus.carry_in, bus.acc[DATA_W-1:1]};
  wire [DATA_W-1:0] rlc_val  = {bus.acc[DATA_W-2:0], bus.carry_in};
  wire              is_logic = bus.op inside {ICTA_AND, ICTA_OR, ICTA_XOR,
                                              ICTA_CPL};

  always_comb begin
    bus.result    = bus.acc;
    bus.carry_out = bus.carry_in;
    bus.carry_we  = 1'b0;
    bus.to_acc    = 1'b0;
    bus.to_reg    = 1'b0;
    unique case (bus.op)
      ICTA_MOVE_R_TO_A: begin
        bus.result = bus.reg_in;
        bus.to_acc = 1'b1;
      end
      ICTA_MOVE_A_TO_R: begin
        bus.result = bus.acc;
        bus.to_reg = 1'b1;
      end
      ICTA_MOVE_K_TO_A: begin
        bus.result = bus.imm;
        bus.to_acc = 1'b1;
      end
      ICTA_ADD: begin
        bus.result    = add_sum[DATA_W-1:0];
        bus.carry_out = add_sum[DATA_W];
        bus.carry_we  = 1'b1;
        bus.to_acc    = 1'b1;
      end
      ICTA_SUB: begin
        // Carry is the inverted borrow, so it is low when a borrow occurs.
        bus.result    = sub_dif[DATA_W-1:0];
        bus.carry_out = ~sub_dif[DATA_W];
        bus.carry_we  = 1'b1;
        bus.to_acc    = 1'b1;
      end
      ICTA_INC_R: begin
        bus.result = inc_val;
        bus.to_reg = 1'b1;
      end
      ICTA_INC_A: begin
        bus.result = increment_to_acc_val;
        bus.to_acc = 1'b1;
      end
      ICTA_DEC_R: begin
        bus.result = dec_val;
        bus.to_reg = 1'b1;
      end
      ICTA_DEC_A: begin
        bus.result = decrement_to_acc_val;
        bus.to_acc = 1'b1;
      end
      ICTA_AND: begin
        bus.result = bus.acc & bus.reg_in;
        bus.to_acc = 1'b1;
      end
      ICTA_OR: begin
        bus.result = bus.acc | bus.reg_in;
        bus.to_acc = 1'b1;
      end
      ICTA_XOR: begin
        bus.result = bus.acc ^ bus.reg_in;
        bus.to_acc = 1'b1;
      end
      ICTA_CPL: begin
        bus.result = ~bus.acc;
        bus.to_acc = 1'b1;
      end
      ICTA_RR: begin
        bus.result = rr_val;
        bus.to_acc = 1'b1;
      end
      ICTA_RL: begin
        bus.result = rl_val;
        bus.to_acc = 1'b1;
      end
      ICTA_RRC: begin
        bus.result    = rrc_val;
        bus.carry_out = bus.acc[0];
        bus.carry_we  = 1'b1;
        bus.to_acc    = 1'b1;
      end
      ICTA_RLC: begin
        bus.result    = rlc_val;
        bus.carry_out = bus.acc[DATA_W-1];
        bus.carry_we  = 1'b1;
        bus.to_acc    = 1'b1;
      end
      default: begin
        bus.result = bus.acc;
      end
    endcase
  end

  assign bus.zero_we  = is_logic;
  assign bus.zero_out = (bus.result == 8'h00);

endmodule : icta_alu

// >>> instruction_cycle_timing_alu_tb.sv
// Self-checking testbench for the instruction cycle sequencer and data path.
`timescale 1ns/1ps
module instruction_cycle_timing_alu_tb;
  import icta_pkg::*;
  typedef struct {
    icta_op_t op; logic [7:0] k; logic [7:0] rd; logic [7:0] a;
    logic c; logic z; logic we; logic [7:0] wd; logic loose;
  } icta_row_t;
  logic       clock = 1'b0;
  logic       resetn = 1'b0;
  icta_op_t   instr_op = ICTA_NOP;
  logic [7:0] instr_imm = 8'h00;
  logic       instr_dest_pcl = 1'b0;
  logic       skip_cond = 1'b0;
  logic [7:0] reg_rdata = 8'h00;
  logic       reg_we, pcl_we, cycle_strobe, instr_take, flush_cycle;
  logic [7:0] reg_wdata, acc;
  logic       carry, zero;
  int         n_fail = 0;
  int         checks_done = 0;
  icta_row_t  rows [20];
  icta_op_t   flow [8];
  logic       to_pcl;
  logic [7:0] pcl_exp;

  always #12.5 clock = ~clock;

  icta_core dut (.clock(clock), .resetn(resetn), .instr_op(instr_op),
    .instr_imm(instr_imm), .instr_dest_pcl(instr_dest_pcl),
    .skip_cond(skip_cond), .reg_rdata(reg_rdata), .reg_we(reg_we),
    .reg_wdata(reg_wdata), .pcl_we(pcl_we), .cycle_strobe(cycle_strobe),
    .instr_take(instr_take), .flush_cycle(flush_cycle), .acc(acc),
    .carry(carry), .zero(zero));

  task automatic check(input logic [31:0] seen, exp, input string what);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value at %0t: %s seen %h expected %h", $time, what,
               seen, exp);
    end
  endtask : check

  task automatic summarize();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : summarize

  // Presents one instruction for a whole cycle, starting at a falling edge.
  task automatic step(input icta_op_t op, input logic [7:0] k, rd,
                      input logic pc_low_byte, sk);
    int early;
    early = 0;
    instr_op = op;
    instr_imm = k;
    reg_rdata = rd;
    instr_dest_pcl = pc_low_byte;
    skip_cond = sk;
    repeat (3) begin
      @(negedge clock);
      if ((cycle_strobe | instr_take | flush_cycle | reg_we | pcl_we)
          !== 1'b0) early++;
    end
    @(negedge clock);
    check(early, 0, "pulse before cycle end");
    check(cycle_strobe, 1'b1, "cycle end strobe");
  endtask : step

  initial begin
    #(25ns * 3000);
    n_fail++;
    summarize();
  end

  initial begin
    rows = '{
      '{ICTA_MOVE_K_TO_A, 8'hF0, 8'h00, 8'hF0, 0, 0, 0, 8'h00, 0},
      '{ICTA_ADD,         8'h00, 8'h20, 8'h10, 1, 0, 0, 8'h00, 0},
      '{ICTA_ADD,         8'h00, 8'hEF, 8'hFF, 0, 0, 0, 8'h00, 0},
      '{ICTA_SUB,         8'h00, 8'h01, 8'hFE, 1, 0, 0, 8'h00, 0},
      '{ICTA_SUB,         8'h00, 8'hFF, 8'hFF, 0, 0, 0, 8'h00, 0},
      '{ICTA_INC_A,       8'h00, 8'h00, 8'h00, 0, 0, 0, 8'h00, 0},
      '{ICTA_DEC_A,       8'h00, 8'h00, 8'hFF, 0, 0, 0, 8'h00, 0},
      '{ICTA_INC_R,       8'h00, 8'h7F, 8'hFF, 0, 0, 1, 8'h80, 0},
      '{ICTA_DEC_R,       8'h00, 8'h00, 8'hFF, 0, 0, 1, 8'hFF, 0},
      '{ICTA_MOVE_R_TO_A, 8'h00, 8'h3C, 8'h3C, 0, 0, 0, 8'h00, 0},
      '{ICTA_MOVE_A_TO_R, 8'h00, 8'h00, 8'h3C, 0, 0, 1, 8'h3C, 0},
      '{ICTA_AND,         8'h00, 8'hC3, 8'h00, 0, 1, 0, 8'h00, 0},
      '{ICTA_OR,          8'h00, 8'h81, 8'h81, 0, 0, 0, 8'h00, 0},
      '{ICTA_XOR,         8'h00, 8'h81, 8'h00, 0, 1, 0, 8'h00, 0},
      '{ICTA_CPL,         8'h00, 8'h00, 8'hFF, 0, 0, 0, 8'h00, 0},
      '{ICTA_MOVE_K_TO_A, 8'h81, 8'h00, 8'h81, 0, 0, 0, 8'h00, 0},
      '{ICTA_RR,          8'h00, 8'h00, 8'hC0, 0, 0, 0, 8'h00, 0},
      '{ICTA_RL,          8'h00, 8'h00, 8'h81, 0, 0, 0, 8'h00, 0},
      '{ICTA_RRC,         8'h00, 8'h00, 8'h40, 1, 0, 0, 8'h00, 0},
      '{ICTA_RLC,         8'h00, 8'h00, 8'h81, 0, 0, 0, 8'h00, 0}};
    flow = '{ICTA_JUMP, ICTA_CALL, ICTA_SUB_RET, ICTA_INT_RET,
             ICTA_TABLE_RD, ICTA_SKIP, ICTA_MOVE_A_TO_R, ICTA_INC_R};
    repeat (12) @(negedge clock);
    check({acc, carry, zero, cycle_strobe, reg_we}, 0, "reset");
    resetn = 1'b1;
    foreach (rows[i]) begin
      step(rows[i].op, rows[i].k, rows[i].rd, 1'b0, 1'b0);
      check(instr_take, 1'b1, "ordinary take");
      check(flush_cycle, 1'b0, "no flush after ordinary");
      check(zero, rows[i].z, "zero flag");
      check(carry, rows[i].c, "carry flag");
      if (!rows[i].loose) begin
        check(acc, rows[i].a, "accumulator");
        check(reg_we, rows[i].we, "register write");
        if (rows[i].we) check(reg_wdata, rows[i].wd, "wdata");
      end
    end
    // Each flow change costs a discarded cycle in which an add is ignored.
    // Two of the three register-destination forms, move and increment, are tried against the low byte.
    foreach (flow[i]) begin
      to_pcl = flow[i] inside {ICTA_MOVE_A_TO_R, ICTA_INC_R};
      pcl_exp = (flow[i] == ICTA_INC_R) ? 8'h01 : 8'h81;
      step(flow[i], 8'h00, 8'h00, to_pcl, flow[i] == ICTA_SKIP);
      check(instr_take, 1'b1, "flow op taken");
      check(pcl_we, to_pcl, "pcl write");
      if (to_pcl) check(reg_wdata, pcl_exp, "pcl data");
      check(reg_we, 1'b0, "no plain write");
      step(ICTA_ADD, 8'h00, 8'h01, 1'b0, 1'b0);
      check(flush_cycle, 1'b1, "extra cycle");
      check(instr_take, 1'b0, "extra cycle not taken");
      check({acc, carry}, {8'h81, 1'b0}, "state kept");
      step(ICTA_NOP, 8'h00, 8'h00, 1'b0, 1'b0);
      check({instr_take, flush_cycle}, 2'b10, "back to normal");
    end
    // A skip whose test fails costs no extra cycle.
    step(ICTA_SKIP, 8'h00, 8'h00, 1'b0, 1'b0);
    step(ICTA_ADD, 8'h00, 8'h01, 1'b0, 1'b0);
    check({instr_take, flush_cycle}, 2'b10, "untaken skip");
    check(acc, 8'h82, "add after skip");
    // Reset in mid-run clears the state and restarts the phase count.
    resetn = 1'b0;
    repeat (3) @(negedge clock);
    check({acc, carry, zero, instr_take}, 0, "mid-run reset");
    resetn = 1'b1;
    step(ICTA_MOVE_K_TO_A, 8'h5A, 8'h00, 1'b0, 1'b0);
    check(acc, 8'h5A, "first move after reset");
    summarize();
  end
endmodule : instruction_cycle_timing_alu_tb
